// file: design/dsca_top.sv
/*
  setup, enable/reset control, descriptor area addressing, checksum
  unit and channel arbiter of the transfer_controller.
  assumes a same-clock register port and a same-clock transfer engine
  that fetches the granted descriptor and reports the burst end.
*/
// The address-and-strobe port and the address map were left to the implementer.
`timescale 1ns/1ps
// Functional notes
// R1 - base registers writable only while controller off
// R2 - global reset only when controller, checksum off
// R3 - channel setup locked while on, except command/level
// R4 - channel reset acts only on disabled channel
// R5 - checksum registers writable only while checksum off
// R6 - checksum polynomial, input source, beat width selectable
// R7 - enable bits turn controller and checksum on/off
// R8 - channel on bit via selector turns channel on/off
// R9 - global reset clears all except debug control
// R10 - software prepares valid first descriptor beforehand
// R11 - first descriptors contiguous from descriptor base
// R12 - ongoing descriptors contiguous from write-back base
// R13 - each channel takes 128 bits of area
// R14 - equal or separate bases both work
// R15 - trigger on enabled unsuspended channel sets pending; the code sets it only while the controller is also on
// R16 - grant clears pending, sets or keeps busy
// R17 - requeue keeps busy; wait/suspend/disable clears it
// R18 - suspend dequeues but keeps pending; resume requeues
// R19 - disable dequeues and clears pending
// R20 - level executing when pending or transferring there
// R21 - four allowed levels, lower number wins
// R22 - static level: lowest channel number wins
// R23 - rotating level: last granted goes last
// R24 - one-beat atomic burst, switch at boundaries
// R25 - protected writes are dropped silently
module dsca_top
  import dsca_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic [5:0] trig_in,
  input wire logic cpu_halted,
  input wire logic burst_done,
  input wire dsca_next_e burst_next,
  input wire logic [31:0] burst_data,
  output logic grant_valid,
  output logic [2:0] grant_ch,
  output logic grant_ongoing,
  output logic [31:0] fetch_addr,
  output logic [31:0] wb_addr
);

  dsca_state_s s_q; // registered state
  dsca_state_s s_d; // next state
  logic [5:0] elig; // channels in the arbitration queue
  logic [3:0] lvl_exec; // per-level executing flags
  logic [2:0] sel; // channel picked by the selector
  logic found; // arbiter has a winner
  logic [2:0] win_ch; // arbiter winner
  logic [1:0] win_lvl; // level of the winner
  logic [5:0] m; // eligible mask of one level
  logic [2:0] st; // search start of one level
  logic cw; // any register write this cycle
  logic [1:0] nbytes; // checksum beat width code

  // first set bit of mask, searching upward from start with wrap
  function automatic logic [2:0] pick(input logic [5:0] mask,
                                      input logic [2:0] start);
    logic [2:0] res;
    int idx;
    res = 3'h0;
    for (int k = DSCA_NCH - 1; k >= 0; k--) begin
      idx = (int'(start) + k) % DSCA_NCH;
      if (mask[idx]) begin
        res = 3'(idx);
      end
    end
    return res;
  endfunction

  // one checksum beat: crc16 msb-first, crc32 reflected lsb-first
  function automatic logic [31:0] crc_beat(input logic [31:0] crc,
                                           input logic [31:0] dat,
                                           input logic [1:0] bw,
                                           input logic [1:0] poly);
    logic [31:0] c;
    logic fb;
    int nb;
    c = crc;
    fb = 1'b0;
    nb = 8 << bw;
    for (int i = 0; i < 32; i++) begin
      if (i < nb) begin
        if (poly == DSCA_POLY_32) begin
          fb = c[0] ^ dat[i];
          c = (c >> 1) ^ (fb ? DSCA_CRC32_P : 32'h0);
        end else begin
          fb = c[15] ^ dat[nb - 1 - i];
          c = {16'h0, c[14:0], 1'b0} ^ (fb ? DSCA_CRC16_P : 32'h0);
        end
      end
    end
    return c;
  endfunction

  // descriptor slot of a channel inside an area
  function automatic logic [31:0] slot(input logic [31:0] base,
                                       input logic [2:0] ch);
    return base + DSCA_DESC_BYTES * {29'h0, ch};
  endfunction

  // queue membership and level executing flags
  always_comb begin
    elig = '0;
    lvl_exec = '0;
    for (int c = 0; c < DSCA_NCH; c++) begin
      // suspended or disabled channels leave the queue
      elig[c] = s_q.pend[c] & s_q.en[c] & ~s_q.susp[c] // R18 R19
                & s_q.lvl_allow[s_q.lvl[c]]; // R21
      if (s_q.pend[c] && s_q.en[c]) begin
        lvl_exec[s_q.lvl[c]] = 1'b1; // R20
      end
    end
    if (s_q.infl) begin
      lvl_exec[s_q.lvl[s_q.act]] = 1'b1; // R20
    end
  end

  // arbiter: lowest level first, static or rotating inside a level
  always_comb begin
    found = 1'b0;
    win_ch = 3'h0;
    win_lvl = 2'h0;
    m = '0;
    st = 3'h0;
    for (int l = DSCA_NLVL - 1; l >= 0; l--) begin
      m = '0;
      for (int c = 0; c < DSCA_NCH; c++) begin
        m[c] = elig[c] && (int'(s_q.lvl[c]) == l);
      end
      if (s_q.rr_en[l]) begin
        // start just after the last winner of this level
        st = (s_q.last[l] == 3'(DSCA_NCH - 1)) ? 3'h0
             : s_q.last[l] + 3'h1; // R23
      end else begin
        st = 3'h0; // R22
      end
      if (|m) begin
        found = 1'b1; // R21
        win_lvl = 2'(l);
        win_ch = pick(m, st);
      end
    end
  end

  assign sel = s_q.chsel;
  assign cw = reg_wr;
  assign nbytes = s_q.crc_bw;

  // next-state logic
  always_comb begin
    s_d = s_q;
    s_d.gnt = 1'b0;
    s_d.rdata = 32'h0;
    // grant only between bursts, never mid-burst; halted debug stops it
    if (s_q.on && !s_q.infl && found && !(cpu_halted && !s_q.dbg)) begin
      s_d.infl = 1'b1; // R24
      s_d.act = win_ch;
      s_d.gnt = 1'b1;
      s_d.gnt_ong = s_q.busy[win_ch];
      s_d.pend[win_ch] = 1'b0; // R16
      s_d.busy[win_ch] = 1'b1; // R16
      s_d.last[win_lvl] = win_ch; // R23
      // first fetch from the descriptor area, later ones write-back
      s_d.fadr = s_q.busy[win_ch] ? slot(s_q.wrb_base, win_ch)
                 : slot(s_q.desc_base, win_ch); // R11 R13 R14
      s_d.wadr = slot(s_q.wrb_base, win_ch); // R12 R13 R14
    end
    // end of the granted burst decides the channel's follow-up
    if (burst_done && s_q.infl) begin
      s_d.infl = 1'b0;
      case (burst_next)
        DSCA_NX_REQUEUE: begin
          s_d.pend[s_q.act] = 1'b1; // R17
        end
        DSCA_NX_WAIT: begin
          s_d.busy[s_q.act] = 1'b0; // R17
        end
        DSCA_NX_SUSPEND: begin
          s_d.busy[s_q.act] = 1'b0; // R17
          s_d.susp[s_q.act] = 1'b1;
        end
        DSCA_NX_DISABLE: begin
          s_d.busy[s_q.act] = 1'b0; // R17
          s_d.en[s_q.act] = 1'b0;
          s_d.pend[s_q.act] = 1'b0;
        end
        default: begin
          s_d.busy[s_q.act] = 1'b0;
        end
      endcase
      // channel-fed checksum takes the finished beat
      if (s_q.crc_on && s_q.crc_src == (DSCA_CSRC_CH | {3'h0, s_q.act})) begin
        s_d.crc_val = crc_beat(s_q.crc_val, burst_data, nbytes,
                               s_q.crc_poly); // R6
      end
    end
    // register writes
    if (cw) begin
      case (reg_addr)
        DSCA_A_CTRL: begin
          s_d.on = reg_wdata[DSCA_B_ON]; // R7
          s_d.crc_on = reg_wdata[DSCA_B_CRCON]; // R7
          s_d.lvl_allow = reg_wdata[DSCA_F_LVLEN +: 4]; // R21
        end
        DSCA_A_CRCSET: begin
          if (!s_q.crc_on) begin // R5 R25
            s_d.crc_bw = reg_wdata[DSCA_F_CBW +: 2]; // R6
            s_d.crc_poly = reg_wdata[DSCA_F_CPOLY +: 2]; // R6
            s_d.crc_src = reg_wdata[DSCA_F_CSRC +: 6]; // R6
          end
        end
        DSCA_A_CRCVAL: begin
          if (!s_q.crc_on) begin // R5 R25
            s_d.crc_val = reg_wdata;
          end
        end
        DSCA_A_CRCDAT: begin
          // register-fed checksum, one beat per write
          if (s_q.crc_on && s_q.crc_src == DSCA_CSRC_IO) begin
            s_d.crc_val = crc_beat(s_q.crc_val, reg_wdata, nbytes,
                                   s_q.crc_poly); // R6
          end
        end
        DSCA_A_DEBUG: begin
          s_d.dbg = reg_wdata[0];
        end
        DSCA_A_PRIO: begin
          s_d.rr_en = reg_wdata[DSCA_F_RRL +: 4]; // R22 R23
        end
        DSCA_A_DBASE: begin
          if (!s_q.on) begin // R1 R25
            s_d.desc_base = reg_wdata;
          end
        end
        DSCA_A_WBASE: begin
          if (!s_q.on) begin // R1 R25
            s_d.wrb_base = reg_wdata;
          end
        end
        DSCA_A_CHSEL: begin
          s_d.chsel = reg_wdata[2:0];
        end
        DSCA_A_CHON: begin
          if (reg_wdata[DSCA_B_CHRST]) begin
            if (!s_q.en[sel]) begin // R4 R25
              s_d.en[sel] = 1'b0;
              s_d.susp[sel] = 1'b0;
              s_d.pend[sel] = 1'b0;
              s_d.busy[sel] = 1'b0;
              s_d.tsrc[sel] = 6'h0;
              s_d.tact[sel] = 2'h0;
              s_d.lvl[sel] = 2'h0;
            end
          end else begin
            s_d.en[sel] = reg_wdata[DSCA_B_CHON]; // R8
            if (!reg_wdata[DSCA_B_CHON]) begin
              s_d.pend[sel] = 1'b0; // R19
              s_d.busy[sel] = 1'b0; // R17
            end
          end
        end
        DSCA_A_CHSET: begin
          if (!s_q.en[sel]) begin // R3 R25
            s_d.tsrc[sel] = reg_wdata[DSCA_F_TSRC +: 6];
            s_d.tact[sel] = reg_wdata[DSCA_F_TACT +: 2];
          end
          s_d.lvl[sel] = reg_wdata[DSCA_F_LVL +: 2]; // R3
          case (dsca_cmd_e'(reg_wdata[DSCA_F_CMD +: 2]))
            DSCA_CMD_SUSPEND: begin
              s_d.susp[sel] = 1'b1; // R18
              s_d.busy[sel] = 1'b0; // R17
            end
            DSCA_CMD_RESUME: begin
              s_d.susp[sel] = 1'b0; // R18
            end
            default: begin
              s_d.susp[sel] = s_d.susp[sel];
            end
          endcase
        end
        default: begin
          s_d.chsel = s_d.chsel;
        end
      endcase
    end
    // triggers last, so a new request beats a same-cycle grant clear; a same-cycle disable still drops it
    for (int c = 0; c < DSCA_NCH; c++) begin
      if (trig_in[c] && s_q.on && s_d.en[c] && !s_d.susp[c]) begin
        s_d.pend[c] = 1'b1; // R15
      end
    end
    // read data, returned the cycle after the strobe
    if (reg_rd) begin
      case (reg_addr)
        DSCA_A_CTRL: s_d.rdata = {20'h0, s_q.lvl_allow, 5'h0,
                                  s_q.crc_on, s_q.on, 1'b0};
        DSCA_A_CRCSET: s_d.rdata = {18'h0, s_q.crc_src, 4'h0,
                                    s_q.crc_poly, s_q.crc_bw};
        DSCA_A_CRCVAL: s_d.rdata = s_q.crc_val;
        DSCA_A_DEBUG: s_d.rdata = {31'h0, s_q.dbg};
        DSCA_A_PRIO: s_d.rdata = {12'h0, s_q.rr_en, 4'h0, s_q.last};
        DSCA_A_PEND: s_d.rdata = {26'h0, s_q.pend};
        DSCA_A_BUSY: s_d.rdata = {26'h0, s_q.busy};
        DSCA_A_ACTIVE: s_d.rdata = {24'h0, s_q.infl, s_q.act, lvl_exec};
        DSCA_A_DBASE: s_d.rdata = s_q.desc_base;
        DSCA_A_WBASE: s_d.rdata = s_q.wrb_base;
        DSCA_A_CHSEL: s_d.rdata = {29'h0, sel};
        DSCA_A_CHON: s_d.rdata = {30'h0, s_q.en[sel], 1'b0};
        DSCA_A_CHSET: s_d.rdata = {8'h0, s_q.tact[sel], 8'h0,
                                   s_q.tsrc[sel], 1'b0, s_q.lvl[sel],
                                   5'h0};
        DSCA_A_CHSTAT: s_d.rdata = {29'h0, s_q.susp[sel],
                                    s_q.busy[sel], s_q.pend[sel]};
        default: s_d.rdata = 32'h0;
      endcase
    end
    // global soft reset wipes all but the debug run control
    if (cw && reg_addr == DSCA_A_CTRL && reg_wdata[DSCA_B_SWRST]
        && !s_q.on && !s_q.crc_on) begin // R2
      s_d = DSCA_RST; // R9
      s_d.dbg = s_q.dbg; // R9
    end
  end

  // state register
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s_q <= DSCA_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // outputs straight from the state flops
  assign reg_rdata = s_q.rdata;
  assign grant_valid = s_q.gnt;
  assign grant_ch = s_q.act;
  assign grant_ongoing = s_q.gnt_ong;
  assign fetch_addr = s_q.fadr;
  assign wb_addr = s_q.wadr;

  // checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  a_base_locked: assert property ( // R1
    reg_wr && reg_addr == DSCA_A_DBASE && s_q.on
    |=> s_q.desc_base == $past(s_q.desc_base))
    else $error("descriptor base changed while controller on");
  a_swrst_locked: assert property ( // R2
    reg_wr && reg_addr == DSCA_A_CTRL && reg_wdata[DSCA_B_SWRST]
    && (s_q.on || s_q.crc_on) && !(reg_wdata == 32'h1)
    |=> $stable(s_q.desc_base))
    else $error("global reset acted while enabled");
  a_setup_locked: assert property ( // R3
    reg_wr && reg_addr == DSCA_A_CHSET && s_q.en[sel]
    |=> s_q.tsrc[$past(sel)] == $past(s_q.tsrc[sel]))
    else $error("channel setup changed while channel on");
  a_chan_reset: assert property ( // R4
    reg_wr && reg_addr == DSCA_A_CHON && reg_wdata[DSCA_B_CHRST]
    && !s_q.en[sel] |=> s_q.tsrc[$past(sel)] == 6'h0
    && !s_q.busy[$past(sel)])
    else $error("channel reset did not clear the channel");
  a_crc_locked: assert property ( // R5
    reg_wr && reg_addr == DSCA_A_CRCVAL && s_q.crc_on && !burst_done
    |=> $stable(s_q.crc_val))
    else $error("checksum value changed while unit on");
  a_trig_pend: assert property ( // R15
    trig_in[0] && s_q.on && s_q.en[0] && !s_q.susp[0] && !reg_wr
    && !burst_done |=> s_q.pend[0])
    else $error("trigger did not set pending");
  a_grant_busy: assert property ( // R16
    grant_valid |-> s_q.busy[grant_ch] && s_q.infl)
    else $error("granted channel not busy");
  a_burst_atomic: assert property ( // R24
    grant_valid |=> !grant_valid ##1 (!grant_valid || $past(burst_done)))
    else $error("second grant inside a burst");
  a_disable_pend: assert property ( // R19
    reg_wr && reg_addr == DSCA_A_CHON && reg_wdata[1:0] == 2'h0
    |=> !s_q.pend[$past(sel)] && !s_q.busy[$past(sel)])
    else $error("disable left pending or busy set");
  a_suspend_keep: assert property ( // R18
    s_q.pend[0] && s_q.susp[0] && !reg_wr |=> !(grant_valid
    && grant_ch == 3'h0) && s_q.pend[0])
    else $error("suspended channel granted or lost pending");

  c_rr_grant: cover property (
    grant_valid && s_q.rr_en[s_q.lvl[grant_ch]] ##[1:20] grant_valid);
  c_ongoing: cover property (grant_valid && grant_ongoing);
  c_crc_io: cover property (
    reg_wr && reg_addr == DSCA_A_CRCDAT && s_q.crc_on);
endmodule

// file: inc/dsca_pkg.sv
/*
  shared constants and types for the transfer_controller setup and
  channel arbiter: register offsets, field positions, reset values and
  the state record of the block.
  assumes a 32-bit register port with byte offsets on an 8-bit address.
*/
package dsca_pkg;
  // sizes of the channel and level sets
  localparam int unsigned DSCA_NCH = 6;
  localparam int unsigned DSCA_NLVL = 4;
  // register byte offsets
  localparam logic [7:0] DSCA_A_CTRL = 8'h00;
  localparam logic [7:0] DSCA_A_CRCSET = 8'h04;
  localparam logic [7:0] DSCA_A_CRCVAL = 8'h08;
  localparam logic [7:0] DSCA_A_CRCDAT = 8'h0c;
  localparam logic [7:0] DSCA_A_DEBUG = 8'h10;
  localparam logic [7:0] DSCA_A_PRIO = 8'h14;
  localparam logic [7:0] DSCA_A_PEND = 8'h18;
  localparam logic [7:0] DSCA_A_BUSY = 8'h1c;
  localparam logic [7:0] DSCA_A_ACTIVE = 8'h20;
  localparam logic [7:0] DSCA_A_DBASE = 8'h24;
  localparam logic [7:0] DSCA_A_WBASE = 8'h28;
  localparam logic [7:0] DSCA_A_CHSEL = 8'h2c;
  localparam logic [7:0] DSCA_A_CHON = 8'h30;
  localparam logic [7:0] DSCA_A_CHSET = 8'h34;
  localparam logic [7:0] DSCA_A_CHSTAT = 8'h38;
  // control register fields
  localparam int unsigned DSCA_B_SWRST = 0;
  localparam int unsigned DSCA_B_ON = 1;
  localparam int unsigned DSCA_B_CRCON = 2;
  localparam int unsigned DSCA_F_LVLEN = 8;
  // channel on/reset register fields
  localparam int unsigned DSCA_B_CHRST = 0;
  localparam int unsigned DSCA_B_CHON = 1;
  // channel setup fields
  localparam int unsigned DSCA_F_LVL = 5;
  localparam int unsigned DSCA_F_TSRC = 8;
  localparam int unsigned DSCA_F_TACT = 22;
  localparam int unsigned DSCA_F_CMD = 24;
  // checksum setup fields, then the rotating-level field of the priority register
  localparam int unsigned DSCA_F_CBW = 0;
  localparam int unsigned DSCA_F_CPOLY = 2;
  localparam int unsigned DSCA_F_CSRC = 8;
  localparam int unsigned DSCA_F_RRL = 16;
  // checksum input codes: register i/o, or channel base plus number
  localparam logic [5:0] DSCA_CSRC_IO = 6'h01;
  localparam logic [5:0] DSCA_CSRC_CH = 6'h20;
  // checksum polynomials
  localparam logic [1:0] DSCA_POLY_16 = 2'h0;
  localparam logic [1:0] DSCA_POLY_32 = 2'h1;
  localparam logic [31:0] DSCA_CRC16_P = 32'h00001021;
  localparam logic [31:0] DSCA_CRC32_P = 32'hedb88320;
  // one descriptor is 128 bits, i.e. 16 bytes
  localparam logic [31:0] DSCA_DESC_BYTES = 32'h00000010;
  // channel commands
  typedef enum logic [1:0] {
    DSCA_CMD_NOP, DSCA_CMD_SUSPEND, DSCA_CMD_RESUME, DSCA_CMD_RSVD
  } dsca_cmd_e;
  // what a channel does after its granted burst
  typedef enum logic [1:0] {
    DSCA_NX_REQUEUE, DSCA_NX_WAIT, DSCA_NX_SUSPEND, DSCA_NX_DISABLE
  } dsca_next_e;
  // whole state of the block
  typedef struct packed {
    logic on;
    logic crc_on;
    logic [3:0] lvl_allow;
    logic dbg;
    logic [3:0] rr_en;
    logic [3:0][2:0] last;
    logic [31:0] desc_base;
    logic [31:0] wrb_base;
    logic [2:0] chsel;
    logic [5:0] en;
    logic [5:0] susp;
    logic [5:0] pend;
    logic [5:0] busy;
    logic [5:0][5:0] tsrc;
    logic [5:0][1:0] tact;
    logic [5:0][1:0] lvl;
    logic [1:0] crc_bw;
    logic [1:0] crc_poly;
    logic [5:0] crc_src;
    logic [31:0] crc_val;
    logic infl;
    logic [2:0] act;
    logic gnt;
    logic gnt_ong;
    logic [31:0] fadr;
    logic [31:0] wadr;
    logic [31:0] rdata;
  } dsca_state_s;
  localparam dsca_state_s DSCA_RST = '0;
endpackage

// file: sim/dsca_engine_model.sv
/*
  transfer engine model: answers each grant with one beat, a fixed
  number of cycles later, and reports what the channel does next.
  assumes the arbiter's grant pulse and one shared clock.
*/
`timescale 1ns/1ps
module dsca_engine_model
  import dsca_pkg::*;
#(
  parameter int DELAY = 2
)(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic grant_valid,
  input wire dsca_next_e nx,
  output logic burst_done,
  output dsca_next_e burst_next,
  output logic [31:0] burst_data
);
  int cnt; // cycles left until the beat ends
  // one atomic beat per grant, then a single done pulse
  always @(posedge clk_sys) begin
    burst_done <= 1'b0;
    burst_data <= ~burst_data; // data inverted every cycle, so the last beat value recurs every other cycle
    if (rst) begin
      cnt <= 0;
      burst_next <= DSCA_NX_WAIT;
      burst_data <= 32'h00000000;
    end else if (grant_valid) begin
      cnt <= DELAY;
    end else if (cnt == 1) begin
      burst_done <= 1'b1;
      burst_next <= nx;
      burst_data <= 32'h0000a5c3;
      cnt <= 0;
    end else if (cnt != 0) begin
      cnt <= cnt - 1;
    end
  end
endmodule

// file: sim/test_dsca_top.sv
/*
  self-checking bench for the setup block and channel arbiter.
  assumes the engine model answers every grant.
*/
`timescale 1ns/1ps
module test_dsca_top;
  import dsca_pkg::*;
  localparam logic [31:0] DB = 32'h20000000; // descriptor base
  localparam logic [31:0] WB = 32'h20000100; // write-back base
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic cpu_halted = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h00000000;
  logic [5:0] trig_in = 6'h00;
  logic [31:0] reg_rdata, fetch_addr, wb_addr, burst_data, rd_q;
  logic grant_valid, grant_ongoing, burst_done;
  logic [2:0] grant_ch;
  dsca_next_e burst_next;
  dsca_next_e nx_q = DSCA_NX_WAIT; // follow-up the engine reports
  int bad_count = 0;
  int comparisons = 0;
  // free-running system clock
  always #50 clk_sys = ~clk_sys;
  dsca_top dut_u (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .trig_in(trig_in), .cpu_halted(cpu_halted),
    .burst_done(burst_done), .burst_next(burst_next),
    .burst_data(burst_data), .grant_valid(grant_valid),
    .grant_ch(grant_ch), .grant_ongoing(grant_ongoing),
    .fetch_addr(fetch_addr), .wb_addr(wb_addr));
  dsca_engine_model #(.DELAY(2)) eng_u (.clk_sys(clk_sys), .rst(rst),
    .grant_valid(grant_valid), .nx(nx_q), .burst_done(burst_done),
    .burst_next(burst_next), .burst_data(burst_data));
  // compare one value
  task chk(input logic [31:0] got, input logic [31:0] exp,
           input string what);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  // one-cycle write strobe
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask
  // one-cycle read strobe, data taken in the following cycle
  task rchk(input logic [7:0] a, input logic [31:0] exp, input string w);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    @(negedge clk_sys);
    rd_q = reg_rdata;
    chk(rd_q, exp, w);
  endtask
  // select, set level, switch on
  task ch_cfg(input logic [2:0] ch, input logic [1:0] lvl);
    wr(DSCA_A_CHSEL, {29'h0, ch});
    wr(DSCA_A_CHSET, {25'h0, lvl, 5'h00});
    wr(DSCA_A_CHON, 32'h00000002);
  endtask
  // one-cycle trigger pulse
  task trig(input logic [5:0] m);
    @(posedge clk_sys);
    trig_in <= m;
    @(posedge clk_sys);
    trig_in <= 6'h00;
  endtask
  // wait for a grant and check where its descriptor lives
  task exp_grant(input logic [2:0] ch, input logic ong);
    logic seen;
    logic [31:0] off;
    seen = 1'b0;
    off = {25'h0, ch, 4'h0};
    for (int n = 0; n < 40 && !seen; n++) begin
      @(negedge clk_sys);
      seen = (grant_valid === 1'b1);
    end
    chk({31'h0, seen}, 32'h1, "grant");
    chk({29'h0, grant_ch}, {29'h0, ch}, "channel");
    chk({31'h0, grant_ongoing}, {31'h0, ong}, "ongoing");
    chk(fetch_addr, (ong ? WB : DB) + off, "fetch");
    chk(wb_addr, WB + off, "wb slot");
  endtask
  // no grant for a span
  task no_grant(input int cyc);
    logic seen;
    seen = 1'b0;
    repeat (cyc) begin
      @(negedge clk_sys);
      seen = seen | (grant_valid === 1'b1);
    end
    chk({31'h0, seen}, 32'h0, "stray grant");
  endtask
  // bases writable while off only
  task t_bases;
    wr(DSCA_A_DBASE, DB);
    wr(DSCA_A_WBASE, WB);
    rchk(DSCA_A_WBASE, WB, "wbase");
    wr(DSCA_A_CTRL, 32'h00000f02);
    wr(DSCA_A_DBASE, 32'h30000000);
    rchk(DSCA_A_DBASE, DB, "dbase locked");
    rchk(DSCA_A_CTRL, 32'h00000f02, "ctrl");
    $display("test bases done");
  endtask
  // first fetch, requeue from write-back, busy cleared on wait
  task t_grant;
    ch_cfg(3'h2, 2'h0);
    nx_q = DSCA_NX_REQUEUE;
    trig(6'h04);
    exp_grant(3'h2, 1'b0);
    exp_grant(3'h2, 1'b1);
    nx_q = DSCA_NX_WAIT;
    repeat (6) @(posedge clk_sys);
    rchk(DSCA_A_BUSY, 32'h0, "busy");
    rchk(DSCA_A_PEND, 32'h0, "pend");
    $display("test grant done");
  endtask
  // level order, static and rotating order within a level
  task t_prio;
    ch_cfg(3'h0, 2'h1);
    ch_cfg(3'h1, 2'h0);
    trig(6'h03);
    exp_grant(3'h1, 1'b0);
    exp_grant(3'h0, 1'b0);
    ch_cfg(3'h3, 2'h2);
    ch_cfg(3'h4, 2'h2);
    trig(6'h18);
    exp_grant(3'h3, 1'b0);
    exp_grant(3'h4, 1'b0);
    wr(DSCA_A_PRIO, 32'h00040000);
    trig(6'h08);
    exp_grant(3'h3, 1'b0);
    trig(6'h18);
    exp_grant(3'h4, 1'b0);
    exp_grant(3'h3, 1'b0);
    $display("test priority done");
  endtask
  // suspend keeps pending, resume requeues, disable drops it
  task t_susp;
    @(posedge clk_sys);
    cpu_halted <= 1'b1;
    trig(6'h01);
    rchk(DSCA_A_PEND, 32'h1, "pend");
    // active channel field still holds the last grant, channel 3
    rchk(DSCA_A_ACTIVE, 32'h32, "level exec");
    wr(DSCA_A_CHSEL, 32'h0);
    wr(DSCA_A_CHSET, 32'h01000020);
    rchk(DSCA_A_CHSTAT, 32'h5, "suspended");
    @(posedge clk_sys);
    cpu_halted <= 1'b0;
    no_grant(10);
    wr(DSCA_A_CHSET, 32'h02000020);
    exp_grant(3'h0, 1'b0);
    @(posedge clk_sys);
    cpu_halted <= 1'b1;
    trig(6'h02);
    wr(DSCA_A_CHSEL, 32'h1);
    wr(DSCA_A_CHON, 32'h0);
    rchk(DSCA_A_PEND, 32'h0, "pend dropped");
    wr(DSCA_A_CHSET, 32'h00000520);
    rchk(DSCA_A_CHSET, 32'h00000520, "setup open");
    wr(DSCA_A_CHON, 32'h1);
    rchk(DSCA_A_CHSET, 32'h0, "channel reset");
    wr(DSCA_A_CHSEL, 32'h0);
    wr(DSCA_A_CHON, 32'h1);
    rchk(DSCA_A_CHON, 32'h2, "reset refused");
    @(posedge clk_sys);
    cpu_halted <= 1'b0;
    no_grant(10);
    $display("test suspend done");
  endtask
  // checksum setup locked while its unit runs; one register-fed beat
  task t_crc;
    wr(DSCA_A_CRCSET, 32'h00000106);
    rchk(DSCA_A_CRCSET, 32'h00000106, "crc setup");
    wr(DSCA_A_CRCVAL, 32'h12345678);
    wr(DSCA_A_CTRL, 32'h00000f06);
    wr(DSCA_A_CRCSET, 32'h0);
    wr(DSCA_A_CRCVAL, 32'h0);
    rchk(DSCA_A_CRCSET, 32'h00000106, "crc setup locked");
    rchk(DSCA_A_CRCVAL, 32'h12345678, "crc value locked");
    wr(DSCA_A_CTRL, 32'h00000f02);
    wr(DSCA_A_CRCVAL, 32'h0);
    wr(DSCA_A_CTRL, 32'h00000f06);
    wr(DSCA_A_CRCDAT, 32'h80000000);
    rchk(DSCA_A_CRCVAL, DSCA_CRC32_P, "crc32 beat");
    $display("test checksum done");
  endtask
  // global reset refused while running, keeps debug bit
  task t_swrst;
    wr(DSCA_A_DEBUG, 32'h1);
    wr(DSCA_A_CTRL, 32'h00000f07);
    rchk(DSCA_A_DBASE, DB, "reset refused");
    wr(DSCA_A_CTRL, 32'h0);
    wr(DSCA_A_CTRL, 32'h1);
    rchk(DSCA_A_DBASE, 32'h0, "dbase cleared");
    rchk(DSCA_A_CTRL, 32'h0, "ctrl cleared");
    rchk(DSCA_A_DEBUG, 32'h1, "debug kept");
    $display("test soft reset done");
  endtask
  // verdict and end of run
  task complete_run;
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (20) @(posedge clk_sys);
    rst <= 1'b0;
    t_bases;
    t_grant;
    t_prio;
    t_susp;
    t_crc;
    t_swrst;
    complete_run;
  end
  // hang guard, well beyond the expected run
  initial begin
    repeat (20000) @(posedge clk_sys);
    bad_count++;
    $display("[ERR] %0t watchdog expired", $time);
    complete_run;
  end
endmodule
